// file: verilog/gpio_bank_pkg.sv
// Package: register map, field layout and reset values for the pin bank
`default_nettype none
package gpio_bank_pkg;
    localparam int          NUM_PINS       = 12;
    localparam int          LOW_PINS       = 4;
    localparam int          HIGH_PINS      = 8;
    localparam logic [7:0]  OFS_CFG_LOW    = 8'h18;
    localparam logic [7:0]  OFS_CFG_HIGH   = 8'h1c;
    // Low register field positions
    localparam int          LOW_SEL_LSB    = 12;
    localparam int          LOW_DRV_LSB    = 8;
    localparam int          LOW_DIR_LSB    = 4;
    localparam int          LOW_VAL_LSB    = 0;
    // High register field positions
    localparam int          HIGH_SEL_LSB   = 24;
    localparam int          HIGH_DRV_LSB   = 16;
    localparam int          HIGH_DIR_LSB   = 8;
    localparam int          HIGH_VAL_LSB   = 0;
    // Fallback values when neither image source is present
    localparam logic [3:0]  RST_SEL_LOW    = 4'hf;
    localparam logic [7:0]  RST_SEL_HIGH   = 8'hff;
    localparam logic [11:0] RST_DRV        = 12'h000;
    localparam logic [11:0] RST_DIR        = 12'h000;
    localparam logic [11:0] RST_VAL        = 12'h000;
endpackage
`default_nettype wire

// file: verilog/gpio_pin_config_bank.sv
// Module: configuration, drive and readback logic for twelve general purpose pins
// Summary of operation
// - Select bit zero gives a pin to general purpose control; low bits 15:12.
// - High register select bits 31:24, pin 4 at bit 24 up to pin 11.
// - Drive-type set is push/pull, clear is open-drain; low 11:8, high 23:16.
// - Direction set enables the output driver; low bits 7:4, pin 0 at bit 4.
// - High register direction bits 15:8, pin 4 at bit 8.
// - Push/pull output pins drive their value bit; open-drain outputs pull low on a clear bit and release on a set bit.
// - Reading a value bit returns the sampled pin level, not the stored value.
// - High register value bits 7:0, pin 4 at bit 0.
// - A pin is a wake or interrupt source only while it is an input.
// - A wake source also needs its enable in the wake control register.
// - Low select field resets to image, else OTP, else 0xf.
// - High select field resets to image, else OTP, else 0xff.
// - Drive, direction and value fields reset to image, else OTP, else zero.
// - Bus or light soft reset restores the last loaded image or fallback.
// - Value bit of an input pin follows the pin, so its reset value is undefined.
// - Protected resets leave every field unchanged while protection is on.
`default_nettype none
module gpio_pin_config_bank #(
    parameter int NPINS = gpio_bank_pkg::NUM_PINS
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [7:0]        addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [31:0]       rdata,
    input  wire logic              eeprom_present,
    input  wire logic              otp_present,
    input  wire logic [4*NPINS-1:0] eeprom_image,
    input  wire logic [4*NPINS-1:0] otp_image,
    input  wire logic              image_load,
    input  wire logic              bus_reset,
    input  wire logic              light_soft_reset,
    input  wire logic              reset_protect,
    input  wire logic [NPINS-1:0]  wake_enable,
    input  wire logic [NPINS-1:0]  pin_in,
    output logic      [NPINS-1:0]  pin_out,
    output logic      [NPINS-1:0]  pin_oe_n,
    output logic      [NPINS-1:0]  gpio_mode,
    output logic      [NPINS-1:0]  irq_source,
    output logic      [NPINS-1:0]  wake_source
);
    // How the bank behaves, for whoever touches it next:
    // - Two registers share one configuration copy; the low word carries pins 0..3,
    //   the high word pins 4..11. Bits 31:16 of the low word have no storage.
    // - A stored image keeps the last loaded defaults so that a bus or light soft
    //   reset can put them back without another EEPROM or OTP fetch.
    // - An image load wins over a restore, and both win over a register write in the
    //   same cycle; software must not rely on a write that collides with either.
    // - While reset protection is high the restore request is ignored entirely.
    // - Pin levels arrive from the board with no relation to clk, so they pass two
    //   flops before the read path sees them; a pin change shows up in a read two
    //   cycles late at the earliest.
    // - Every pin output is registered, so a configuration change reaches the pins
    //   one cycle after it reaches the configuration copy.
    // - Pins handed to their alternate function are released here entirely.

    // Image layout: {select, drive, direction, value}, NPINS bits each
    typedef struct packed {
        logic [NPINS-1:0] sel;
        logic [NPINS-1:0] drv;
        logic [NPINS-1:0] dir;
        logic [NPINS-1:0] val;
    } cfg_s;

    typedef struct packed {
        cfg_s             cfg;
        cfg_s             image;
        logic [NPINS-1:0] sync1;
        logic [NPINS-1:0] sync2;
        logic [31:0]      rdata;
        logic [NPINS-1:0] pin_out;
        logic [NPINS-1:0] pin_oe_n;
        logic [NPINS-1:0] gpio_mode;
        logic [NPINS-1:0] irq_source;
        logic [NPINS-1:0] wake_source;
    } state_s;

    localparam int LP = gpio_bank_pkg::LOW_PINS;
    localparam int HP = gpio_bank_pkg::HIGH_PINS;

    state_s st;
    state_s next_st;
    cfg_s   fallback;
    cfg_s   loaded;
    cfg_s   after_wr;
    logic   restore;

    // Fallback image when no EEPROM or OTP is present
    always_comb begin
        fallback.sel = {gpio_bank_pkg::RST_SEL_HIGH, gpio_bank_pkg::RST_SEL_LOW};
        fallback.drv = gpio_bank_pkg::RST_DRV;
        fallback.dir = gpio_bank_pkg::RST_DIR;
        fallback.val = gpio_bank_pkg::RST_VAL;
    end

    // Image source priority: EEPROM, then OTP, then fixed values
    always_comb begin
        if (eeprom_present) begin
            loaded = cfg_s'(eeprom_image);
        end else if (otp_present) begin
            loaded = cfg_s'(otp_image);
        end else begin
            loaded = fallback;
        end
    end

    // Protected resets are blocked while retention is active
    assign restore = (bus_reset | light_soft_reset) & ~reset_protect;

    // Register writes into a copy of the configuration
    always_comb begin
        after_wr = st.cfg;
        if (wr && addr == gpio_bank_pkg::OFS_CFG_LOW) begin
            // Bits 31:16 of the low register are dropped
            after_wr.sel[LP-1:0] = wdata[gpio_bank_pkg::LOW_SEL_LSB +: LP];
            after_wr.drv[LP-1:0] = wdata[gpio_bank_pkg::LOW_DRV_LSB +: LP];
            after_wr.dir[LP-1:0] = wdata[gpio_bank_pkg::LOW_DIR_LSB +: LP];
            after_wr.val[LP-1:0] = wdata[gpio_bank_pkg::LOW_VAL_LSB +: LP];
        end else if (wr && addr == gpio_bank_pkg::OFS_CFG_HIGH) begin
            after_wr.sel[NPINS-1:LP] = wdata[gpio_bank_pkg::HIGH_SEL_LSB +: HP];
            after_wr.drv[NPINS-1:LP] = wdata[gpio_bank_pkg::HIGH_DRV_LSB +: HP];
            after_wr.dir[NPINS-1:LP] = wdata[gpio_bank_pkg::HIGH_DIR_LSB +: HP];
            after_wr.val[NPINS-1:LP] = wdata[gpio_bank_pkg::HIGH_VAL_LSB +: HP];
        end
    end

    // Next-state logic for the whole bank
    always_comb begin
        next_st       = st;
        next_st.sync1 = pin_in;
        next_st.sync2 = st.sync1;
        if (image_load) begin
            next_st.image = loaded;
            next_st.cfg   = loaded;
        end else if (restore) begin
            next_st.cfg = st.image;
        end else begin
            next_st.cfg = after_wr;
        end
        // Read data stands in the cycle after the strobe only
        next_st.rdata = 32'h0000_0000;
        if (rd && addr == gpio_bank_pkg::OFS_CFG_LOW) begin
            next_st.rdata[gpio_bank_pkg::LOW_SEL_LSB +: LP] = st.cfg.sel[LP-1:0];
            next_st.rdata[gpio_bank_pkg::LOW_DRV_LSB +: LP] = st.cfg.drv[LP-1:0];
            next_st.rdata[gpio_bank_pkg::LOW_DIR_LSB +: LP] = st.cfg.dir[LP-1:0];
            next_st.rdata[gpio_bank_pkg::LOW_VAL_LSB +: LP] = st.sync2[LP-1:0];
        end else if (rd && addr == gpio_bank_pkg::OFS_CFG_HIGH) begin
            next_st.rdata[gpio_bank_pkg::HIGH_SEL_LSB +: HP] = st.cfg.sel[NPINS-1:LP];
            next_st.rdata[gpio_bank_pkg::HIGH_DRV_LSB +: HP] = st.cfg.drv[NPINS-1:LP];
            next_st.rdata[gpio_bank_pkg::HIGH_DIR_LSB +: HP] = st.cfg.dir[NPINS-1:LP];
            next_st.rdata[gpio_bank_pkg::HIGH_VAL_LSB +: HP] = st.sync2[NPINS-1:LP];
        end
        // Pin drivers and source qualifiers, per pin
        for (int i = 0; i < NPINS; i++) begin
            next_st.gpio_mode[i] = ~st.cfg.sel[i];
            if (~st.cfg.sel[i] && st.cfg.dir[i]) begin
                if (st.cfg.drv[i]) begin
                    next_st.pin_out[i]  = st.cfg.val[i];
                    next_st.pin_oe_n[i] = 1'b0;
                end else begin
                    next_st.pin_out[i]  = 1'b0;
                    next_st.pin_oe_n[i] = st.cfg.val[i];
                end
            end else begin
                next_st.pin_out[i]  = 1'b0;
                next_st.pin_oe_n[i] = 1'b1;
            end
            next_st.irq_source[i]  = ~st.cfg.sel[i] & ~st.cfg.dir[i];
            next_st.wake_source[i] = ~st.cfg.sel[i] & ~st.cfg.dir[i] & wake_enable[i];
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st          <= '0;
            st.cfg.sel  <= {gpio_bank_pkg::RST_SEL_HIGH, gpio_bank_pkg::RST_SEL_LOW};
            st.image.sel <= {gpio_bank_pkg::RST_SEL_HIGH, gpio_bank_pkg::RST_SEL_LOW};
            st.pin_oe_n <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign rdata       = st.rdata;
    assign pin_out     = st.pin_out;
    assign pin_oe_n    = st.pin_oe_n;
    assign gpio_mode   = st.gpio_mode;
    assign irq_source  = st.irq_source;
    assign wake_source = st.wake_source;

    // Checks on the registered behaviour
    a_open_drain_high: assert property (@(posedge clk) disable iff (!nrst)
        (~pin_oe_n & pin_out & ~$past(st.cfg.drv)) == '0)
        else $error("open drain pin driven high");
    a_push_pull_drive: assert property (@(posedge clk) disable iff (!nrst)
        ($past(~st.cfg.sel[0] & st.cfg.dir[0] & st.cfg.drv[0]))
        |-> (!pin_oe_n[0] && pin_out[0] == $past(st.cfg.val[0])))
        else $error("push pull pin 0 wrong");
    a_od_release: assert property (@(posedge clk) disable iff (!nrst)
        ($past(st.cfg.dir[1] & ~st.cfg.drv[1] & ~st.cfg.sel[1]))
        |-> (!pin_out[1] && pin_oe_n[1] == $past(st.cfg.val[1])))
        else $error("open drain pin 1 wrong");
    a_input_released: assert property (@(posedge clk) disable iff (!nrst)
        $past(st.cfg.dir[2] == 1'b0) |-> pin_oe_n[2])
        else $error("input pin driven");
    a_irq_input: assert property (@(posedge clk) disable iff (!nrst)
        irq_source[5] |-> $past(st.cfg.dir[5] == 1'b0))
        else $error("output pin flagged as source");
    a_wake_enable: assert property (@(posedge clk) disable iff (!nrst)
        wake_source[3] |-> $past(wake_enable[3]) && irq_source[3])
        else $error("wake without enable");
    a_low_reserved: assert property (@(posedge clk) disable iff (!nrst)
        $past(rd) && $past(addr) == gpio_bank_pkg::OFS_CFG_LOW |-> rdata[31:16] == 16'h0000)
        else $error("low reserved bits nonzero");
    a_read_pin: assert property (@(posedge clk) disable iff (!nrst)
        rd && addr == gpio_bank_pkg::OFS_CFG_HIGH |=> rdata[7:0] == $past(st.sync2[11:4]))
        else $error("read value not pin level");
    a_high_write: assert property (@(posedge clk) disable iff (!nrst)
        wr && addr == gpio_bank_pkg::OFS_CFG_HIGH && !image_load && !restore
        |=> st.cfg.sel[11:4] == $past(wdata[31:24]))
        else $error("high select write lost");
    a_restore_image: assert property (@(posedge clk) disable iff (!nrst)
        restore && !image_load |=> st.cfg == $past(st.image))
        else $error("restore missed image");
    a_protect_hold: assert property (@(posedge clk) disable iff (!nrst)
        reset_protect && (bus_reset | light_soft_reset) && !wr && !image_load
        |=> $stable(st.cfg))
        else $error("protected field changed");

    // Alternate function pins are never driven from here
    a_alt_released: assert property (@(posedge clk) disable iff (!nrst)
        ($past(st.cfg.sel) & ~pin_oe_n) == '0)
        else $error("alternate function pin driven");

    // Input pins are never driven, on any pin
    a_inputs_released: assert property (@(posedge clk) disable iff (!nrst)
        ($past(~st.cfg.dir) & ~pin_oe_n) == '0)
        else $error("input pin driven");

    // Mode flag is the inverse of the select bit of the previous cycle
    a_mode_follow: assert property (@(posedge clk) disable iff (!nrst)
        gpio_mode == ~$past(st.cfg.sel))
        else $error("mode flag wrong");

    // Push/pull outputs always drive
    a_pp_enabled: assert property (@(posedge clk) disable iff (!nrst)
        ($past(~st.cfg.sel & st.cfg.dir & st.cfg.drv) & pin_oe_n) == '0)
        else $error("push pull pin released");

    // Push/pull outputs carry the written value bit
    a_pp_value: assert property (@(posedge clk) disable iff (!nrst)
        ($past(~st.cfg.sel & st.cfg.dir & st.cfg.drv) & (pin_out ^ $past(st.cfg.val))) == '0)
        else $error("push pull value wrong");

    // No output pin may be an interrupt source
    a_irq_outputs: assert property (@(posedge clk) disable iff (!nrst)
        (irq_source & $past(st.cfg.dir)) == '0)
        else $error("output pin flagged on some pin");

    // A wake source is always an interrupt source too
    a_wake_subset: assert property (@(posedge clk) disable iff (!nrst)
        (wake_source & ~irq_source) == '0)
        else $error("wake source not an input");

    // Read data is zero outside the cycle after a read strobe
    a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
        !$past(rd) |-> rdata == 32'h0000_0000)
        else $error("read data outside read cycle");

    // Unmapped addresses read zero
    a_unmapped_read: assert property (@(posedge clk) disable iff (!nrst)
        $past(rd) && $past(addr) != gpio_bank_pkg::OFS_CFG_LOW
        && $past(addr) != gpio_bank_pkg::OFS_CFG_HIGH |-> rdata == 32'h0000_0000)
        else $error("unmapped read nonzero");

    // Unmapped writes leave the configuration alone
    a_unmapped_write: assert property (@(posedge clk) disable iff (!nrst)
        wr && addr != gpio_bank_pkg::OFS_CFG_LOW && addr != gpio_bank_pkg::OFS_CFG_HIGH
        && !image_load && !restore |=> $stable(st.cfg))
        else $error("unmapped write changed configuration");

    // Low register write lands in the low pins' fields
    a_low_write: assert property (@(posedge clk) disable iff (!nrst)
        wr && addr == gpio_bank_pkg::OFS_CFG_LOW && !image_load && !restore
        |=> st.cfg.sel[3:0] == $past(wdata[15:12]) && st.cfg.drv[3:0] == $past(wdata[11:8])
        && st.cfg.dir[3:0] == $past(wdata[7:4]) && st.cfg.val[3:0] == $past(wdata[3:0]))
        else $error("low write lost");

    // High register direction and value fields land on pins 4 to 11
    a_high_fields: assert property (@(posedge clk) disable iff (!nrst)
        wr && addr == gpio_bank_pkg::OFS_CFG_HIGH && !image_load && !restore
        |=> st.cfg.dir[11:4] == $past(wdata[15:8]) && st.cfg.val[11:4] == $past(wdata[7:0])
        && st.cfg.drv[11:4] == $past(wdata[23:16]))
        else $error("high fields write lost");

    // High register read returns the configuration fields
    a_high_read: assert property (@(posedge clk) disable iff (!nrst)
        rd && addr == gpio_bank_pkg::OFS_CFG_HIGH |=> rdata[31:8] ==
        $past({st.cfg.sel[11:4], st.cfg.drv[11:4], st.cfg.dir[11:4]}))
        else $error("high read fields wrong");

    // Low register value bits read the sampled pin level
    a_low_pin_read: assert property (@(posedge clk) disable iff (!nrst)
        rd && addr == gpio_bank_pkg::OFS_CFG_LOW |=> rdata[3:0] == $past(st.sync2[3:0]))
        else $error("low read value not pin level");

    // EEPROM image has first claim on the defaults
    a_load_eeprom: assert property (@(posedge clk) disable iff (!nrst)
        image_load && eeprom_present |=> st.cfg == cfg_s'($past(eeprom_image))
        && st.image == st.cfg)
        else $error("eeprom image not loaded");

    // OTP image is used when no EEPROM is present
    a_load_otp: assert property (@(posedge clk) disable iff (!nrst)
        image_load && !eeprom_present && otp_present |=> st.cfg == cfg_s'($past(otp_image)))
        else $error("otp image not loaded");

    // Fixed values when neither source is present
    a_load_fixed: assert property (@(posedge clk) disable iff (!nrst)
        image_load && !eeprom_present && !otp_present
        |=> st.cfg.sel == 12'hfff && st.cfg.drv == 12'h000 && st.cfg.dir == 12'h000)
        else $error("fallback values not loaded");

    // The stored image only changes on a load
    a_image_hold: assert property (@(posedge clk) disable iff (!nrst)
        !image_load |=> $stable(st.image))
        else $error("stored image changed without load");
endmodule
`default_nettype wire

// file: tb/gpio_board_model.sv
// Board side of the twelve pins: pull-ups plus optional external drivers
`default_nettype none
module gpio_board_model (
    input  wire logic [11:0] pin_out,
    input  wire logic [11:0] pin_oe_n,
    input  wire logic [11:0] ext_en,
    input  wire logic [11:0] ext_val,
    output logic      [11:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Wire level: device driver wins, then board driver, else the pull-up
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else
                pin_in[i] = 1'h1;
        end
    end
endmodule
`default_nettype wire

// file: tb/gpio_pin_config_bank_tb.sv
// Self-checking testbench for the twelve pin configuration bank
`default_nettype none
module gpio_pin_config_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, image_load = 1'h0;
    logic        eeprom_present = 1'h0, otp_present = 1'h0, bus_reset = 1'h0;
    logic        light_soft_reset = 1'h0, reset_protect = 1'h0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [47:0] eeprom_image = 48'h0, otp_image = 48'h0;
    logic [11:0] wake_enable = 12'h0, ext_en = 12'h0, ext_val = 12'h0;
    logic [11:0] pin_in, pin_out, pin_oe_n, gpio_mode, irq_source, wake_source;
    int          err_count = 0, checks = 0;
    // Clock and units under test
    always #5 clk = ~clk;
    gpio_pin_config_bank u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .eeprom_present(eeprom_present),
        .otp_present(otp_present), .eeprom_image(eeprom_image), .otp_image(otp_image),
        .image_load(image_load), .bus_reset(bus_reset),
        .light_soft_reset(light_soft_reset), .reset_protect(reset_protect),
        .wake_enable(wake_enable), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .gpio_mode(gpio_mode), .irq_source(irq_source),
        .wake_source(wake_source));
    gpio_board_model u_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));
    // Shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        settle();
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        image_load <= (k == 0);
        light_soft_reset <= (k == 1);
        bus_reset <= (k == 2);
        @(posedge clk);
        {image_load, light_soft_reset, bus_reset} <= 3'h0;
        settle();
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Scenarios
    task automatic check_defaults();
        settle();
        chk({20'h0, gpio_mode}, 32'h0);
        chk({20'h0, pin_oe_n}, 32'hfff);
        rd_chk(gpio_bank_pkg::OFS_CFG_LOW, 32'h0000f00f);
        rd_chk(gpio_bank_pkg::OFS_CFG_HIGH, 32'hff0000ff);
    endtask
    task automatic check_low_open_drain();
        wr_reg(gpio_bank_pkg::OFS_CFG_LOW, 32'hffff00f5);
        chk({28'h0, gpio_mode[3:0]}, 32'hf);
        chk({28'h0, pin_oe_n[3:0]}, 32'h5);
        rd_chk(gpio_bank_pkg::OFS_CFG_LOW, 32'h000000f5);
        wr_reg(8'h20, 32'hffffffff);
        rd_chk(8'h20, 32'h0);
    endtask
    task automatic check_high_push_pull();
        ext_en <= 12'hf00;
        ext_val <= 12'h600;
        wake_enable <= 12'h300;
        wr_reg(gpio_bank_pkg::OFS_CFG_HIGH, 32'h00ff0fa5);
        chk({28'h0, pin_out[7:4]}, 32'h5);
        chk({24'h0, pin_oe_n[11:4]}, 32'hf0);
        chk({20'h0, irq_source}, 32'hf00);
        chk({20'h0, wake_source}, 32'h300);
        rd_chk(gpio_bank_pkg::OFS_CFG_HIGH, 32'h00ff0f65);
    endtask
    task automatic check_restore();
        ext_en <= 12'h000;
        {eeprom_present, otp_present} <= 2'h3;
        eeprom_image <= {12'h0f0, 36'h0};
        otp_image <= {12'h00f, 36'h0};
        pulse(0);
        rd_chk(gpio_bank_pkg::OFS_CFG_HIGH, 32'h0f0000ff);
        rd_chk(gpio_bank_pkg::OFS_CFG_LOW, 32'h0000000f);
        wr_reg(gpio_bank_pkg::OFS_CFG_HIGH, 32'h0);
        pulse(1);
        rd_chk(gpio_bank_pkg::OFS_CFG_HIGH, 32'h0f0000ff);
        reset_protect <= 1'h1;
        wr_reg(gpio_bank_pkg::OFS_CFG_HIGH, 32'h0);
        pulse(2);
        rd_chk(gpio_bank_pkg::OFS_CFG_HIGH, 32'h000000ff);
        reset_protect <= 1'h0;
        eeprom_present <= 1'h0;
        pulse(0);
        rd_chk(gpio_bank_pkg::OFS_CFG_LOW, 32'h0000f00f);
        otp_present <= 1'h0;
        pulse(0);
        rd_chk(gpio_bank_pkg::OFS_CFG_HIGH, 32'hff0000ff);
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        check_defaults();
        check_low_open_drain();
        check_high_push_pull();
        check_restore();
        conclude();
    end
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule
`default_nettype wire
